// *** src/fwpg_dev.sv ***
// device end: write-enable latch, status register and protect gating
//
// What this block does
// (RL1) page program needs latch set first
// (RL2) sector, block, chip erase need latch
// (RL3) register writes need latch set first
// (RL4) info row and bank writes need latch
// (RL5) sector lock writes need latch first
// (RL6) gang, password, training writes need latch
// (RL7) C0h and 17h run without latch
// (RL8) inhibit program or erase in region
// (RL9) chip erase ignored when code nonzero
// (RL10) disable bit zero: status write always allowed
// (RL11) disable set, pin low: status frozen
// (RL12) disable set, pin high: status writable
// (RL13) quad-enable forces wp_pin_o, hold_pin_o high; status lock still reads pin
// (RL14) end select picks top or bottom
// (RL15) 64KB codes 1..9 power-of-two blocks
// (RL16) 64KB codes 10..15 grow to all
// (RL17) 256KB codes 1..8 power-of-two blocks
// (RL18) 256KB codes 9..15 protect all
// (RL19) write-enable command sets latch
// (RL20) latch clears on disable or completion
// (RL21) rejection leaves array, regs, busy unchanged
`timescale 1ns/1ps
module fwpg_dev
    import fwpg_pkg::*;
#(
    parameter bit BIG_BLOCKS = 1'b0
) (
    // system side, clocks the core
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // link side
    fwpg_link_if.dev               link,
    // engine side, core clock domain
    output logic                   grant_o,
    output logic [7:0]             grant_op_o,
    output logic [ADDR_W-1:0]      grant_addr_o,
    output logic                   reject_o,
    output logic [7:0]             status_o,
    output logic                   quad_mode_o,
    output logic                   wp_pin_o,
    output logic                   hold_pin_o,
    input  wire logic              spare_hold_n_i,
    input  wire logic              area_end_select_i
);
    import fwpg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // link domain: shift in opcode, optional status byte, optional addr
    typedef struct packed {
        logic [5:0]        bitcnt;
        logic [7:0]        op;
        logic [ADDR_W-1:0] sh;
        logic [7:0]        cap_op;
        logic [ADDR_W-1:0] cap_arg;
        logic [5:0]        cap_bits;
    } fwpg_lnk_t;
    fwpg_lnk_t l_q, l_d;

    // command ends at chip-select rise, so the frame's last edge latches
    always_comb begin
        l_d = l_q;
        if (!link.cs_n) begin
            if (l_q.bitcnt != 6'h3F)
                l_d.bitcnt = l_q.bitcnt + 6'h01;
            if (l_q.bitcnt < 6'h08)
                l_d.op = {l_q.op[6:0], link.mosi};
            else
                l_d.sh = {l_q.sh[ADDR_W-2:0], link.mosi};
            // snapshot every edge so the closing frame is always held
            l_d.cap_op   = (l_q.bitcnt < 6'h08) ?
                           {l_q.op[6:0], link.mosi} : l_q.op;
            l_d.cap_arg  = (l_q.bitcnt < 6'h08) ? l_q.sh :
                           {l_q.sh[ADDR_W-2:0], link.mosi};
            l_d.cap_bits = l_q.bitcnt + 6'h01;
            if (l_q.bitcnt == 6'h00)
                l_d.sh = '0;
        end
    end

    // link clock may stop outside frames; the free-running core copies
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        // only the count clears; the capture must outlive chip-select
        if (link.cs_n) begin
            l_q.bitcnt <= 6'h00;
        end else begin
            l_q <= l_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame end event: chip-select rise synchronised into the core
    typedef struct packed {
        logic [1:0]        cs_sync;
        logic              cs_prev;
        logic [1:0]        wp_sync;
        logic [1:0]        hold_sync;
        logic [1:0]        evt;
        logic [7:0]        sr;
        logic [2:0]        busy_cnt;
        logic              grant;
        logic [7:0]        gop;
        logic [ADDR_W-1:0] gaddr;
        logic              reject;
    } fwpg_core_t;
    fwpg_core_t c_q, c_d;

    logic [BLK_W:0] prot_cnt;
    logic [BLK_W-1:0] blk;
    logic in_area;
    logic [3:0] code;

    // protected block count from the four-bit code
    function automatic logic [BLK_W:0] prot_blocks(input logic [3:0] c,
                                                   input logic big);
        logic [BLK_W:0] r;
        r = '0;
        if (big) begin
            if (c >= 4'h9)
                r = (BLK_W+1)'(BLK256_COUNT); // RL18
            else if (c != 4'h0)
                r = (BLK_W+1)'(1) << (c - 4'h1); // RL17
        end else begin
            if (c >= 4'hA)
                r = (BLK_W+1)'(BLK64_COUNT) -
                    ((BLK_W+1)'(BLK64_COUNT) >> (c - 4'h9)); // RL16
            if (c == 4'hF)
                r = (BLK_W+1)'(BLK64_COUNT); // RL16
            else if (c != 4'h0 && c < 4'hA)
                r = (BLK_W+1)'(1) << (c - 4'h1); // RL15
        end
        prot_blocks = r;
    endfunction : prot_blocks

    always_comb begin
        code     = c_q.sr[SR_BP_LSB +: 4];
        prot_cnt = prot_blocks(code, BIG_BLOCKS); // RL8
        blk      = BIG_BLOCKS ?
                   BLK_W'(l_q.cap_arg[BLK256_SHIFT +: 8]) :
                   l_q.cap_arg[BLK64_SHIFT +: BLK_W];
        if (area_end_select_i) // RL14
            in_area = {1'b0, blk} < prot_cnt;
        else
            in_area = ({1'b0, blk} + prot_cnt) >=
                      (BIG_BLOCKS ? (BLK_W+1)'(BLK256_COUNT) :
                                    (BLK_W+1)'(BLK64_COUNT));
    end

    logic frame_end;
    logic latch_on;
    logic [7:0] sr_data;
    logic [7:0] op;
    logic busy;
    logic sr_locked;

    always_comb begin
        c_d         = c_q;
        c_d.cs_sync = {c_q.cs_sync[0], link.cs_n};
        c_d.cs_prev = c_q.cs_sync[1];
        c_d.wp_sync = {c_q.wp_sync[0], link.wp_n};
        c_d.hold_sync = {c_q.hold_sync[0], spare_hold_n_i};
        c_d.grant   = 1'b0;
        c_d.reject  = 1'b0;
        frame_end   = c_q.cs_sync[1] && !c_q.cs_prev;
        latch_on    = c_q.sr[SR_LATCH_POS];
        op          = l_q.cap_op;
        busy        = c_q.busy_cnt != 3'h0;
        sr_locked   = c_q.sr[SR_SWD_POS] && !c_q.wp_sync[1]; // RL11
        // status byte is the first after the opcode, for frames of 16 to 40 bits
        sr_data     = 8'(l_q.cap_arg >> (l_q.cap_bits - 6'h10));
        if (busy) begin
            c_d.busy_cnt = c_q.busy_cnt - 3'h1;
            if (c_q.busy_cnt == 3'h1)
                c_d.sr[SR_LATCH_POS] = 1'b0; // RL20
        end
        // frame data is stable once chip-select has been high two edges
        if (frame_end && !busy && l_q.cap_bits >= 6'h08) begin
            if (op == OP_WR_ENABLE)
                c_d.sr[SR_LATCH_POS] = 1'b1; // RL19
            else if (op == OP_WR_DISABLE)
                c_d.sr[SR_LATCH_POS] = 1'b0; // RL20
            else if (op == OP_RP_V_ALT || op == OP_BANK_V_ALT) begin
                c_d.grant = 1'b1; // RL7
                c_d.gop   = op;
            end else if (fwpg_needs_latch(op)) begin
                // RL21: every refusal below leaves sr and busy as they were
                if (!latch_on) // RL1 RL2 RL3 RL4 RL5 RL6
                    c_d.reject = 1'b1;
                else if ((op == OP_CE_A || op == OP_CE_B) && code != 4'h0)
                    c_d.reject = 1'b1; // RL9
                else if (fwpg_is_array(op) && in_area)
                    c_d.reject = 1'b1; // RL8
                else if (op == OP_STATUS_WR && sr_locked)
                    c_d.reject = 1'b1; // RL11
                else begin
                    if (op == OP_STATUS_WR) // RL10 RL12
                        c_d.sr = (c_q.sr & ~SR_WR_MASK) |
                                 (sr_data & SR_WR_MASK);
                    c_d.grant    = 1'b1;
                    c_d.gop      = op;
                    c_d.gaddr    = l_q.cap_arg;
                    c_d.busy_cnt = 3'(BUSY_CYCLES);
                end
            end
        end
        c_d.sr[0] = c_d.busy_cnt != 3'h0;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            c_q         <= '0;
            c_q.cs_sync <= 2'b11;
            c_q.cs_prev <= 1'b1;
            c_q.sr      <= SR_RESET;
        end else begin
            c_q <= c_d;
        end
    end

    // spare pins: protect and hold inputs unless quad mode
    always_comb begin
        quad_mode_o = c_q.sr[SR_QUAD_POS]; // RL13
        wp_pin_o    = quad_mode_o ? 1'b1 : c_q.wp_sync[1]; // RL13
        hold_pin_o  = quad_mode_o ? 1'b1 : c_q.hold_sync[1]; // RL13
    end

    assign grant_o      = c_q.grant;
    assign grant_op_o   = c_q.gop;
    assign grant_addr_o = c_q.gaddr;
    assign reject_o     = c_q.reject;
    assign status_o     = c_q.sr;
    // read path unused here; the pin is never driven
    assign link.miso    = 1'b0;
    assign link.miso_oe = 1'b0;
endmodule : fwpg_dev

// *** src/fwpg_pkg.sv ***
// shared constants and types for the flash write-protect gate
package fwpg_pkg;
    // opcodes
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_RDSR_CMD  = 8'h05;
    localparam logic [7:0] OP_PAGE_PG   = 8'h02;
    localparam logic [7:0] OP_PP4       = 8'h12;
    localparam logic [7:0] OP_PPQ_A     = 8'h32;
    localparam logic [7:0] OP_PPQ_B     = 8'h38;
    localparam logic [7:0] OP_PPQ4_A    = 8'h34;
    localparam logic [7:0] OP_PPQ4_B    = 8'h3E;
    localparam logic [7:0] OP_SE_A      = 8'hD7;
    localparam logic [7:0] OP_SE_B      = 8'h20;
    localparam logic [7:0] OP_SE4       = 8'h21;
    localparam logic [7:0] OP_BE32      = 8'h52;
    localparam logic [7:0] OP_BE32_4    = 8'h5C;
    localparam logic [7:0] OP_BE64      = 8'hD8;
    localparam logic [7:0] OP_BE64_4    = 8'hDC;
    localparam logic [7:0] OP_CE_A      = 8'hC7;
    localparam logic [7:0] OP_CE_B      = 8'h60;
    localparam logic [7:0] OP_STATUS_WR = 8'h01;
    localparam logic [7:0] OP_FUNC_WR   = 8'h42;
    localparam logic [7:0] OP_RP_NV     = 8'h65;
    localparam logic [7:0] OP_RP_V      = 8'h63;
    localparam logic [7:0] OP_RP_V_ALT  = 8'hC0;
    localparam logic [7:0] OP_XRP_NV    = 8'h85;
    localparam logic [7:0] OP_XRP_V     = 8'h83;
    localparam logic [7:0] OP_IR_ER     = 8'h64;
    localparam logic [7:0] OP_IR_PG     = 8'h62;
    localparam logic [7:0] OP_BANK_NV   = 8'h18;
    localparam logic [7:0] OP_BANK_V    = 8'hC5;
    localparam logic [7:0] OP_BANK_V_ALT = 8'h17;
    localparam logic [7:0] OP_DYB_A     = 8'hFB;
    localparam logic [7:0] OP_DYB_B     = 8'hE1;
    localparam logic [7:0] OP_PPB_A     = 8'hFD;
    localparam logic [7:0] OP_PPB_B     = 8'hE3;
    localparam logic [7:0] OP_PPB_ER    = 8'hE4;
    localparam logic [7:0] OP_PROT_PG   = 8'h2F;
    localparam logic [7:0] OP_LOCKBIT   = 8'hA6;
    localparam logic [7:0] OP_FREEZE    = 8'h91;
    localparam logic [7:0] OP_GANG_LK   = 8'h7E;
    localparam logic [7:0] OP_GANG_UN   = 8'h98;
    localparam logic [7:0] OP_PWD_PG    = 8'hE8;
    localparam logic [7:0] OP_TRN_NV    = 8'h43;
    localparam logic [7:0] OP_TRN_V     = 8'h4A;
    // status register fields
    localparam int         SR_LATCH_POS = 1;
    localparam int         SR_BP_LSB    = 2;
    localparam int         SR_QUAD_POS  = 6;
    localparam int         SR_SWD_POS   = 7;
    localparam logic [7:0] SR_RESET     = 8'h00;
    localparam logic [7:0] SR_WR_MASK   = 8'hFC;
    // block geometry
    localparam int         BLK64_COUNT  = 1024;
    localparam int         BLK256_COUNT = 256;
    localparam int         BLK_W        = 10;
    // address bits below a block
    localparam int         BLK64_SHIFT  = 16;
    localparam int         BLK256_SHIFT = 18;
    localparam int         ADDR_W       = 32;
    localparam int         BUSY_CYCLES  = 4;

    typedef enum logic [2:0] {
        FWPG_OP_NONE  = 3'b001,
        FWPG_OP_PROG  = 3'b010,
        FWPG_OP_CHIP  = 3'b100
    } fwpg_opk_t;

    // decode of an opcode into its gating classes
    function automatic logic fwpg_needs_latch(input logic [7:0] op);
        unique case (op)
            OP_PAGE_PG, OP_PP4, OP_PPQ_A, OP_PPQ_B, OP_PPQ4_A, OP_PPQ4_B,
            OP_SE_A, OP_SE_B, OP_SE4, OP_BE32, OP_BE32_4, OP_BE64,
            OP_BE64_4, OP_CE_A, OP_CE_B, OP_STATUS_WR, OP_FUNC_WR, OP_RP_NV,
            OP_RP_V, OP_XRP_NV, OP_XRP_V, OP_IR_ER, OP_IR_PG,
            OP_BANK_NV, OP_BANK_V, OP_DYB_A, OP_DYB_B, OP_PPB_A,
            OP_PPB_B, OP_PPB_ER, OP_PROT_PG, OP_LOCKBIT, OP_FREEZE,
            OP_GANG_LK, OP_GANG_UN, OP_PWD_PG, OP_TRN_NV,
            OP_TRN_V: fwpg_needs_latch = 1'b1;
            default: fwpg_needs_latch = 1'b0;
        endcase
    endfunction : fwpg_needs_latch

    function automatic logic fwpg_is_array(input logic [7:0] op);
        unique case (op)
            OP_PAGE_PG, OP_PP4, OP_PPQ_A, OP_PPQ_B, OP_PPQ4_A, OP_PPQ4_B,
            OP_SE_A, OP_SE_B, OP_SE4, OP_BE32, OP_BE32_4, OP_BE64,
            OP_BE64_4: fwpg_is_array = 1'b1;
            default: fwpg_is_array = 1'b0;
        endcase
    endfunction : fwpg_is_array
endpackage : fwpg_pkg

// *** src/fwpg_link_if.sv ***
// serial link between the host controller and the protect gate
`timescale 1ns/1ps
interface fwpg_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic wp_n;

    modport dev (
        input  sclk,
        input  cs_n,
        input  mosi,
        input  wp_n,
        output miso,
        output miso_oe
    );
    modport host (
        output sclk,
        output cs_n,
        output mosi,
        output wp_n,
        input  miso,
        input  miso_oe
    );
endinterface : fwpg_link_if

// *** src/fwpg_host.sv ***
// host end: sends one command frame per request on a divided clock
`timescale 1ns/1ps
module fwpg_host
    import fwpg_pkg::*;
#(
    parameter int DIV = 2
) (
    // system
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // request
    input  wire logic              req_i,
    input  wire logic [7:0]        req_op_i,
    input  wire logic [ADDR_W-1:0] req_arg_i,
    input  wire logic [5:0]        req_bits_i,
    input  wire logic              wp_level_i,
    output logic                   ready_o,
    output logic                   done_o,
    // link
    fwpg_link_if.host              link
);
    import fwpg_pkg::*;

    typedef enum logic [2:0] {
        FWPG_H_IDLE = 3'b001,
        FWPG_H_SHIFT = 3'b010,
        FWPG_H_GAP  = 3'b100
    } fwpg_hst_t;

    typedef struct packed {
        fwpg_hst_t         st;
        logic [7:0]        div;
        logic [5:0]        left;
        logic [ADDR_W+7:0] sh;
        logic              sclk;
        logic              cs_n;
        logic              done;
    } fwpg_host_t;
    fwpg_host_t h_q, h_d;

    // command plus argument, msb first; frame gap lets device resync
    always_comb begin
        h_d      = h_q;
        h_d.done = 1'b0;
        unique case (h_q.st)
            FWPG_H_IDLE: begin
                if (req_i) begin
                    h_d.sh   = {req_op_i, req_arg_i};
                    h_d.left = req_bits_i;
                    h_d.cs_n = 1'b0;
                    h_d.div  = '0;
                    h_d.st   = FWPG_H_SHIFT;
                end
            end
            FWPG_H_SHIFT: begin
                h_d.div = h_q.div + 8'h01;
                if (h_q.div == 8'(DIV - 1)) begin
                    h_d.div  = '0;
                    h_d.sclk = ~h_q.sclk;
                    if (h_q.sclk) begin
                        h_d.sh   = {h_q.sh[ADDR_W+6:0], 1'b0};
                        h_d.left = h_q.left - 6'h01;
                        if (h_q.left == 6'h01) begin
                            h_d.st   = FWPG_H_GAP;
                            h_d.cs_n = 1'b1;
                        end
                    end
                end
            end
            FWPG_H_GAP: begin
                h_d.div = h_q.div + 8'h01;
                if (h_q.div == 8'h0F) begin
                    h_d.st   = FWPG_H_IDLE;
                    h_d.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            h_q      <= '0;
            h_q.st   <= FWPG_H_IDLE;
            h_q.cs_n <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end

    assign ready_o   = h_q.st == FWPG_H_IDLE;
    assign done_o    = h_q.done;
    assign link.sclk = h_q.sclk;
    assign link.cs_n = h_q.cs_n;
    assign link.mosi = h_q.sh[ADDR_W+7];
    assign link.wp_n = wp_level_i;
endmodule : fwpg_host

// *** bench/fwpg_assertions.sv ***
// link and answer checks for the flash write-protect gate
`timescale 1ns/1ps
module fwpg_checker (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // link
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       mosi,
    input wire logic       miso,
    input wire logic       miso_oe,
    input wire logic       wp_n,
    // device answers
    input wire logic       grant_o,
    input wire logic       reject_o,
    input wire logic [7:0] status_o
);
    logic [4:0] gap_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    // saturating idle count, starts at 16 so the first frame is legal
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) gap_q <= 5'h10;
        else if (!cs_n) gap_q <= 5'h00;
        else if (gap_q != 5'h1F) gap_q <= gap_q + 5'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    a_frame_gap: assert property ($fell(cs_n) |-> gap_q >= 5'h0F)
        else $error("frames too close together");
    a_idle_clock: assert property (cs_n && $past(cs_n) |-> !sclk)
        else $error("link clock moves outside a frame");
    a_mosi_stable: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("data changed while link clock high");
    a_miso_quiet: assert property (!miso_oe && !miso)
        else $error("device drove its data line");
    a_answer_single: assert property (!(grant_o && reject_o))
        else $error("grant and reject together");
    a_answer_idle: assert property (grant_o || reject_o |-> cs_n)
        else $error("answer given inside a frame");
    a_busy_span: assert property ($rose(status_o[0]) |->
        status_o[0] [*3] ##[1:3] !status_o[0])
        else $error("busy span wrong");
    // busy and grant are registered on the same edge
    a_busy_cause: assert property ($rose(status_o[0]) |-> grant_o)
        else $error("busy without a grant");
    a_latch_done: assert property ($fell(status_o[0]) |->
        ##[0:1] !status_o[1])
        else $error("latch kept after completion");
    a_reject_keeps: assert property (reject_o |=> $stable(status_o))
        else $error("status changed on a refusal");
    c_grant: cover property (grant_o);
    c_reject: cover property (reject_o);
    c_busy: cover property ($rose(status_o[0]));
endmodule : fwpg_checker

// *** bench/flash_write_protect_gate_tb_top.sv ***
// self-checking bench joining host and device ends of the gate
`timescale 1ns/1ps
module flash_write_protect_gate_tb_top;
    import fwpg_pkg::*;
    logic              clk_i, rst_n_i, req_i, wp_level_i, ready_o, done_o;
    logic [7:0]        req_op_i, grant_op_o, status_o;
    logic [ADDR_W-1:0] req_arg_i, grant_addr_o;
    logic [5:0]        req_bits_i;
    logic              grant_o, reject_o, quad_mode_o, wp_pin_o, hold_pin_o;
    logic              spare_hold_n_i, area_end_select_i, saw_g, saw_r, saw_d;
    int                n_errors = 0;
    int                n_compared = 0;
    fwpg_link_if fwpg_link_if_inst ();
    fwpg_host fwpg_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .req_i(req_i), .req_op_i(req_op_i), .req_arg_i(req_arg_i),
        .req_bits_i(req_bits_i), .wp_level_i(wp_level_i),
        .ready_o(ready_o), .done_o(done_o), .link(fwpg_link_if_inst));
    fwpg_dev #(.BIG_BLOCKS(1'b0)) fwpg_dev_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .link(fwpg_link_if_inst), .grant_o(grant_o),
        .grant_op_o(grant_op_o), .grant_addr_o(grant_addr_o),
        .reject_o(reject_o), .status_o(status_o),
        .quad_mode_o(quad_mode_o), .wp_pin_o(wp_pin_o),
        .hold_pin_o(hold_pin_o), .spare_hold_n_i(spare_hold_n_i),
        .area_end_select_i(area_end_select_i));
    fwpg_checker fwpg_checker_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .sclk(fwpg_link_if_inst.sclk), .cs_n(fwpg_link_if_inst.cs_n),
        .mosi(fwpg_link_if_inst.mosi), .miso(fwpg_link_if_inst.miso),
        .miso_oe(fwpg_link_if_inst.miso_oe), .wp_n(fwpg_link_if_inst.wp_n),
        .grant_o(grant_o), .reject_o(reject_o), .status_o(status_o));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // answers are pulses, so latch them for the task that asked
    always @(posedge clk_i) begin
        if (grant_o === 1'b1) saw_g = 1'b1;
        if (reject_o === 1'b1) saw_r = 1'b1;
        if (done_o === 1'b1) saw_d = 1'b1;
    end
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] op, input logic [31:0] arg,
                        input logic [5:0] bits);
        int i;
        @(negedge clk_i);
        {saw_g, saw_r, saw_d} = 3'b000;
        {req_op_i, req_arg_i, req_bits_i, req_i} = {op, arg, bits, 1'b1};
        for (i = 0; i < 50 && ready_o !== 1'b0; i++) @(negedge clk_i);
        req_i = 1'b0;
        for (i = 0; i < 400 && saw_d !== 1'b1; i++) @(negedge clk_i);
        chk(saw_d, "frame never completed");
        for (i = 0; i < 20 && status_o[0] !== 1'b0; i++) @(negedge clk_i);
    endtask : xfer
    task automatic cmd(input logic [7:0] op, input logic [31:0] arg);
        xfer(OP_WR_ENABLE, 32'h0, 6'h08);
        xfer(op, arg, 6'h28);
    endtask : cmd
    task automatic wsr(input logic [7:0] d);
        xfer(OP_WR_ENABLE, 32'h0, 6'h08);
        xfer(OP_STATUS_WR, {d, 24'h0}, 6'h10);
    endtask : wsr
    // protected block count per code, 64KB option
    function automatic int nblk(input int c);
        int t [16] = '{0, 1, 2, 4, 8, 16, 32, 64, 128, 256, 512, 768, 896,
                       960, 992, 1024};
        return t[c];
    endfunction : nblk
    ////////////////////////////////////////////////////////////////////////
    task automatic t_latch();
        xfer(OP_WR_ENABLE, 32'h0, 6'h08);
        chk(status_o[1] === 1'b1, "latch not set");
        xfer(OP_WR_DISABLE, 32'h0, 6'h08);
        chk(status_o[1] === 1'b0, "latch not cleared");
        cmd(OP_PAGE_PG, 32'h0);
        chk(saw_g && status_o[1] === 1'b0, "latch kept");
        $display("test latch done");
    endtask : t_latch
    task automatic t_need();
        logic [7:0] ops [38] = '{OP_PAGE_PG, OP_PP4, OP_PPQ_A, OP_PPQ_B,
            OP_PPQ4_A, OP_PPQ4_B, OP_SE_A, OP_SE_B, OP_SE4, OP_BE32,
            OP_BE32_4, OP_BE64, OP_BE64_4, OP_CE_A, OP_CE_B, OP_STATUS_WR,
            OP_FUNC_WR, OP_RP_NV, OP_RP_V, OP_XRP_NV, OP_XRP_V, OP_IR_ER,
            OP_IR_PG, OP_BANK_NV, OP_BANK_V, OP_DYB_A, OP_DYB_B, OP_PPB_A,
            OP_PPB_B, OP_PPB_ER, OP_PROT_PG, OP_LOCKBIT, OP_FREEZE,
            OP_GANG_LK, OP_GANG_UN, OP_PWD_PG, OP_TRN_NV, OP_TRN_V};
        foreach (ops[k]) begin
            xfer(OP_WR_DISABLE, 32'h0, 6'h08);
            xfer(ops[k], 32'h0, 6'h28);
            chk(saw_r && !saw_g, "ran without latch");
            chk(status_o === 8'h00, "refusal changed status");
            cmd(ops[k], 32'h0);
            chk(saw_g && grant_op_o === ops[k], "refused with latch");
        end
        $display("test latch list done");
    endtask : t_need
    task automatic t_alt();
        xfer(OP_WR_DISABLE, 32'h0, 6'h08);
        xfer(OP_RP_V_ALT, 32'h0, 6'h28);
        chk(saw_g && !saw_r, "alternate read write refused");
        xfer(OP_BANK_V_ALT, 32'h0, 6'h28);
        chk(saw_g && !saw_r, "alternate bank write refused");
        $display("test alternates done");
    endtask : t_alt
    task automatic t_protect();
        int n;
        logic [31:0] a;
        for (int e = 0; e < 2; e++) begin
            area_end_select_i = e[0];
            for (int c = 1; c < 16; c++) begin
                n = nblk(c);
                wsr({2'b00, c[3:0], 2'b00});
                chk(status_o[5:2] === c[3:0], "code not written");
                cmd(OP_PAGE_PG, 32'(e ? n - 1 : BLK64_COUNT - n) << BLK64_SHIFT);
                chk(saw_r && !saw_g, "protected block written");
                if (n < BLK64_COUNT) begin
                    a = 32'(e ? n : BLK64_COUNT - 1 - n) << BLK64_SHIFT;
                    cmd(OP_SE_B, a);
                    chk(saw_g && !saw_r, "free block refused");
                    chk(grant_addr_o === a, "granted address wrong");
                end
            end
            cmd(OP_CE_A, 32'h0);
            chk(!saw_g, "chip erase ran while protected");
            wsr(8'h00);
        end
        $display("test protect areas done");
    endtask : t_protect
    task automatic t_status_lock();
        wp_level_i = 1'b0;
        wsr(8'h84);
        chk(status_o[7:2] === 6'h21, "write refused, disable clear");
        wsr(8'h00);
        chk(status_o[7:2] === 6'h21 && !saw_g, "frozen status written");
        wp_level_i = 1'b1;
        wsr(8'h00);
        chk(status_o[7:2] === 6'h00, "write refused, pin high");
        $display("test status protect done");
    endtask : t_status_lock
    task automatic t_quad();
        {wp_level_i, spare_hold_n_i} = 2'b00;
        repeat (8) @(negedge clk_i);
        chk({quad_mode_o, wp_pin_o, hold_pin_o} === 3'b000, "pins");
        wsr(8'h40);
        chk({quad_mode_o, wp_pin_o, hold_pin_o} === 3'b111, "quad");
        {wp_level_i, spare_hold_n_i} = 2'b11;
        wsr(8'h00);
        $display("test quad pins done");
    endtask : t_quad
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    initial begin
        {rst_n_i, req_i, wp_level_i, spare_hold_n_i} = 4'b0011;
        {req_op_i, req_arg_i, req_bits_i} = '0;
        {area_end_select_i, saw_g, saw_r, saw_d} = 4'h0;
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_latch();
        t_need();
        t_alt();
        t_protect();
        t_status_lock();
        t_quad();
        close_out();
    end
    // about 350 frames of at most some 230 cycles each
    initial begin
        #500000;
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end
endmodule : flash_write_protect_gate_tb_top
